// ---- core/ommd_params.svh ----
// address map, capacity and view constants for the on-chip memory map decoder
`ifndef OMMD_PARAMS_SVH
`define OMMD_PARAMS_SVH

`define OMMD_CPU_DA_END   32'h0000_ffff
`define OMMD_MMR_END      32'h0000_00c0
`define OMMD_CPU_SA_BASE  32'h0001_0000
`define OMMD_CPU_SA_END   32'h0004_ffff
`define OMMD_CPU_ROM_BASE 32'h00fe_0000
`define OMMD_CPU_ROM_END  32'h00ff_ffff
`define OMMD_DMA_DA_BASE  32'h0001_0000
`define OMMD_DMA_DA_END   32'h0001_ffff
`define OMMD_DMA_SA_BASE  32'h0009_0000
`define OMMD_DMA_SA_END   32'h000c_ffff
`define OMMD_SA_BLOCKS    6'h20
`define OMMD_DA_CAP       2'h2
`define OMMD_ONE_CAP      2'h1
`define OMMD_VIEW_CPU     2'h0
`define OMMD_VIEW_DMA     2'h1
`define OMMD_VIEW_USB     2'h2
`define OMMD_M_PROG       0
`define OMMD_M_DATA       1
`define OMMD_M_DMA        2
`define OMMD_M_USB        3
`define OMMD_RAM_BLK_HI   17
`define OMMD_RAM_BLK_LO   13
`define OMMD_RAM_WRD_HI   12
`define OMMD_ROM_BLK_HI   16
`define OMMD_ROM_BLK_LO   15
`define OMMD_ROM_WRD_HI   14
`define OMMD_WRD_LO       1

`endif

// ---- core/ommd_pkg.sv ----
// types shared by the on-chip memory map decoder
package ommd_pkg;

  typedef enum logic [3:0] {
    REGION_NONE   = 4'h1,
    REGION_DUAL   = 4'h2,
    REGION_SINGLE = 4'h4,
    REGION_ROM    = 4'h8
  } ommd_region_t;

  typedef struct packed {
    ommd_region_t region;
    logic [4:0]   blk;
    logic [13:0]  waddr;
    logic         mmr;
  } ommd_dec_t;

  typedef struct packed {
    logic [3:0]              ack;
    logic [3:0]              we;
    logic [3:0]              mmr;
    ommd_region_t [3:0]      region;
    logic [3:0][4:0]         blk;
    logic [3:0][13:0]        waddr;
    logic                    unmap;
  } ommd_state_t;

endpackage : ommd_pkg

// ---- core/ommd_decoder.sv ----
// on-chip memory map decoder with per-block access arbitration
`timescale 1ns/1ps
`default_nettype none
`include "ommd_params.svh"

// Contract
// R1 - cpu bytes 0..ffff go to eight dual-access blocks
// R2 - dual-access block takes two accesses per cycle
// R3 - dual-access ram reachable from cpu and dma
// R4 - dma sees dual-access ram at 10000h
// R5 - lowest 192 bytes are cpu mapped registers
// R6 - top range fe0000h..ffffffh is the rom
// R7 - unmap bit set removes rom from map
// R8 - hardware reset clears the unmap bit
// R9 - software reset leaves unmap bit unchanged
// R10 - rom reachable from cpu buses only
// R11 - rom block serves one word per cycle
// R12 - cpu 10000h..4ffffh go to 32 single-access blocks
// R13 - single-access block serves one access per cycle
// R14 - single-access ram reachable also from usb bus
// R15 - dma and usb see single-access at 90000h
// R16 - last single-access block untouched while booting
// R17 - smallest variant has no single-access blocks
// R18 - dma moves a 32-bit word per cycle; the decoder grants one 16-bit word per access (byte address bit 0 dropped)
// R19 - over-subscribed block grants capacity, stalls rest
// R20 - unmapped access completes without any write
module ommd_decoder
  import ommd_pkg::*;
#(
  parameter logic [5:0] SA_BLOCKS = `OMMD_SA_BLOCKS
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst_n,
  input  wire logic [3:0]       i_req,
  input  wire logic [3:0]       i_we,
  input  wire logic [31:0]      i_addr_prog,
  input  wire logic [31:0]      i_addr_data,
  input  wire logic [31:0]      i_addr_dma,
  input  wire logic [31:0]      i_addr_usb,
  input  wire logic             i_unmap_wr,
  input  wire logic             i_unmap_wdata,
  input  wire logic             i_soft_reset,
  output logic [3:0]            o_ack,
  output logic [3:0]            o_mem_we,
  output logic [3:0]            o_mmr,
  output logic [3:0][3:0]       o_region,
  output logic [3:0][4:0]       o_blk,
  output logic [3:0][13:0]      o_waddr,
  output logic                  o_rom_unmap_select
);

  localparam ommd_state_t ST_RESET = '{
    ack:    4'h0,
    we:     4'h0,
    mmr:    4'h0,
    region: '{4{REGION_NONE}},
    blk:    20'h0,
    waddr:  56'h0,
    unmap:  1'b0
  };

  logic [1:0]        rst_sync;
  logic              rst_n;
  ommd_state_t       st;
  ommd_state_t       next_st;
  logic [3:0][31:0]  addr;
  ommd_dec_t [3:0]   dec;
  logic [3:0]        grant;

  // maps one master's byte address onto region, block and word
  function automatic ommd_dec_t decode(
    input logic [1:0]  view,
    input logic [31:0] a,
    input logic        unmap,
    input logic [5:0]  nsa
  );
    ommd_dec_t   d;
    logic [31:0] off;
    d   = '{region: REGION_NONE, blk: 5'h0, waddr: 14'h0, mmr: 1'b0};
    off = 32'h0;
    if (view == `OMMD_VIEW_CPU) begin
      if (a <= `OMMD_CPU_DA_END) begin // R1
        d.region = REGION_DUAL;
        off      = a;
      end else if (a >= `OMMD_CPU_SA_BASE && a <= `OMMD_CPU_SA_END) begin // R12
        d.region = REGION_SINGLE;
        off      = a - `OMMD_CPU_SA_BASE;
      end else if (a >= `OMMD_CPU_ROM_BASE && a <= `OMMD_CPU_ROM_END && !unmap) begin // R6 R7
        d.region = REGION_ROM;
        off      = a - `OMMD_CPU_ROM_BASE;
      end
    end else begin
      // dma windows never reach the rom
      if (view == `OMMD_VIEW_DMA && a >= `OMMD_DMA_DA_BASE
          && a <= `OMMD_DMA_DA_END) begin // R3 R4 R10
        d.region = REGION_DUAL;
        off      = a - `OMMD_DMA_DA_BASE;
      end else if (a >= `OMMD_DMA_SA_BASE && a <= `OMMD_DMA_SA_END) begin // R14 R15
        d.region = REGION_SINGLE;
        off      = a - `OMMD_DMA_SA_BASE;
      end
    end
    case (d.region)
      REGION_DUAL, REGION_SINGLE: begin
        d.blk   = off[`OMMD_RAM_BLK_HI:`OMMD_RAM_BLK_LO];
        d.waddr = {2'h0, off[`OMMD_RAM_WRD_HI:`OMMD_WRD_LO]};
      end
      REGION_ROM: begin
        d.blk   = {3'h0, off[`OMMD_ROM_BLK_HI:`OMMD_ROM_BLK_LO]};
        d.waddr = off[`OMMD_ROM_WRD_HI:`OMMD_WRD_LO];
      end
      default: begin
        d.blk   = 5'h0;
        d.waddr = 14'h0;
      end
    endcase
    // blocks beyond the fitted count are not backed
    if (d.region == REGION_SINGLE && {1'b0, d.blk} >= nsa) begin // R17
      d.region = REGION_NONE;
    end
    // register window takes no storage slot
    if (d.region == REGION_DUAL && off < `OMMD_MMR_END) begin // R5
      d.region = REGION_NONE;
      d.mmr    = 1'b1;
    end
    return d;
  endfunction : decode

  // accesses a block can take in one cycle
  function automatic logic [1:0] cap(input ommd_region_t r);
    logic [1:0] c;
    c = `OMMD_ONE_CAP;
    if (r == REGION_DUAL) begin
      c = `OMMD_DA_CAP; // R2
    end
    return c; // R11 R13
  endfunction : cap

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  assign addr[`OMMD_M_PROG] = i_addr_prog;
  assign addr[`OMMD_M_DATA] = i_addr_data;
  assign addr[`OMMD_M_DMA]  = i_addr_dma;
  assign addr[`OMMD_M_USB]  = i_addr_usb;

  always_comb begin
    logic [1:0] used;
    used    = 2'h0;
    next_st = st;
    dec[`OMMD_M_PROG] = decode(`OMMD_VIEW_CPU, addr[`OMMD_M_PROG], st.unmap, SA_BLOCKS);
    dec[`OMMD_M_DATA] = decode(`OMMD_VIEW_CPU, addr[`OMMD_M_DATA], st.unmap, SA_BLOCKS);
    dec[`OMMD_M_DMA]  = decode(`OMMD_VIEW_DMA, addr[`OMMD_M_DMA], st.unmap, SA_BLOCKS);
    dec[`OMMD_M_USB]  = decode(`OMMD_VIEW_USB, addr[`OMMD_M_USB], st.unmap, SA_BLOCKS);
    // fixed priority: program, data, dma, usb
    for (int m = 0; m < 4; m++) begin
      used = 2'h0;
      for (int k = 0; k < m; k++) begin
        if (grant[k] && dec[k].region != REGION_NONE
            && dec[k].region == dec[m].region && dec[k].blk == dec[m].blk) begin
          used = used + 2'h1;
        end
      end
      grant[m] = i_req[m] && (dec[m].region == REGION_NONE
                              || used < cap(dec[m].region)); // R19
    end
    for (int m = 0; m < 4; m++) begin
      next_st.ack[m]    = grant[m]; // R18 R20
      next_st.we[m]     = grant[m] && i_we[m] && m != `OMMD_M_PROG
                          && (dec[m].region == REGION_DUAL
                              || dec[m].region == REGION_SINGLE
                              || dec[m].mmr); // R20
      next_st.mmr[m]    = grant[m] && dec[m].mmr;
      next_st.region[m] = grant[m] ? dec[m].region : REGION_NONE;
      next_st.blk[m]    = dec[m].blk;
      next_st.waddr[m]  = dec[m].waddr;
    end
    // software reset has no path here
    if (i_unmap_wr) begin // R7 R9
      next_st.unmap = i_unmap_wdata;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_RESET; // R8
    end else begin
      st <= next_st;
    end
  end

  assign o_ack              = st.ack;
  assign o_mem_we           = st.we;
  assign o_mmr              = st.mmr;
  assign o_region           = st.region;
  assign o_blk              = st.blk;
  assign o_waddr            = st.waddr;
  assign o_rom_unmap_select = st.unmap;

  // helper: capacity overrun seen at the outputs
  logic sa_clash;
  logic da_over;
  always_comb begin
    logic [1:0] n;
    n        = 2'h0;
    sa_clash = 1'b0;
    da_over  = 1'b0;
    for (int m = 0; m < 4; m++) begin
      n = 2'h0;
      for (int k = 0; k < 4; k++) begin
        if (k != m && st.region[k] == st.region[m] && st.blk[k] == st.blk[m]) begin
          if (st.region[m] == REGION_SINGLE || st.region[m] == REGION_ROM) begin
            sa_clash = 1'b1;
          end
          if (st.region[m] == REGION_DUAL && n != 2'h3) begin
            n = n + 2'h1;
          end
        end
      end
      if (n >= `OMMD_DA_CAP) begin
        da_over = 1'b1;
      end
    end
  end

  sequence s_lone_prog;
    i_req == 4'h1;
  endsequence

  sequence s_lone_usb;
    i_req == 4'h8;
  endsequence

  property p_unmap_reset;
    @(posedge i_mclk) $rose(rst_n) |-> !o_rom_unmap_select;
  endproperty
  a_unmap_reset: assert property (p_unmap_reset) // R8
    else $error("rom unmap bit not clear after reset");

  property p_soft_keep;
    @(posedge i_mclk) disable iff (!rst_n)
      i_soft_reset && !i_unmap_wr |=> $stable(o_rom_unmap_select);
  endproperty
  a_soft_keep: assert property (p_soft_keep) // R9
    else $error("software reset changed rom unmap bit");

  property p_rom_gone;
    @(posedge i_mclk) disable iff (!rst_n)
      o_rom_unmap_select && $stable(o_rom_unmap_select)
      |-> o_region[0] != REGION_ROM && o_region[1] != REGION_ROM;
  endproperty
  a_rom_gone: assert property (p_rom_gone) // R7
    else $error("rom selected while unmapped");

  property p_dma_norom;
    @(posedge i_mclk) disable iff (!rst_n)
      o_region[2] != REGION_ROM && o_region[3] != REGION_ROM;
  endproperty
  a_dma_norom: assert property (p_dma_norom) // R10
    else $error("dma master reached the rom");

  property p_usb_sa_only;
    @(posedge i_mclk) disable iff (!rst_n)
      o_ack[3] |-> o_region[3] != REGION_DUAL && !o_mmr[3];
  endproperty
  a_usb_sa_only: assert property (p_usb_sa_only) // R14
    else $error("usb master reached dual-access ram");

  property p_one_cap;
    @(posedge i_mclk) disable iff (!rst_n) !sa_clash;
  endproperty
  a_one_cap: assert property (p_one_cap) // R13
    else $error("single-access block granted twice");

  property p_two_cap;
    @(posedge i_mclk) disable iff (!rst_n) !da_over;
  endproperty
  a_two_cap: assert property (p_two_cap) // R2
    else $error("dual-access block granted three times");

  property p_unmapped_nowrite;
    @(posedge i_mclk) disable iff (!rst_n)
      o_region[1] == REGION_NONE && !o_mmr[1] |-> !o_mem_we[1];
  endproperty
  a_unmapped_nowrite: assert property (p_unmapped_nowrite) // R20
    else $error("write issued to unmapped address");

  property p_dual_decode;
    @(posedge i_mclk) disable iff (!rst_n)
      s_lone_prog ##0 (i_addr_prog >= `OMMD_MMR_END && i_addr_prog <= `OMMD_CPU_DA_END)
      |=> o_ack[0] && o_region[0] == REGION_DUAL && o_blk[0] == {2'h0, $past(i_addr_prog[15:13])};
  endproperty
  a_dual_decode: assert property (p_dual_decode) // R1
    else $error("dual-access decode wrong");

  property p_lone_grant;
    @(posedge i_mclk) disable iff (!rst_n)
      s_lone_usb |=> o_ack == 4'h8 && o_mem_we[2:0] == 3'h0 && o_mmr[3] == 1'b0;
  endproperty
  a_lone_grant: assert property (p_lone_grant) // R19
    else $error("lone request not granted next cycle");

  // program-bus offset into the single-access window
  logic [31:0] prog_sa_off;
  assign prog_sa_off = i_addr_prog - `OMMD_CPU_SA_BASE;

  sequence s_prog_single;
    i_req[0] && i_addr_prog >= `OMMD_CPU_SA_BASE && i_addr_prog <= `OMMD_CPU_SA_END
    && {1'b0, prog_sa_off[`OMMD_RAM_BLK_HI:`OMMD_RAM_BLK_LO]} < SA_BLOCKS;
  endsequence

  property p_single_decode;
    @(posedge i_mclk) disable iff (!rst_n)
      s_prog_single |=> o_ack[0] && o_region[0] == REGION_SINGLE
      && o_blk[0] == $past(prog_sa_off[`OMMD_RAM_BLK_HI:`OMMD_RAM_BLK_LO]);
  endproperty
  a_single_decode: assert property (p_single_decode) // R12 R13
    else $error("single-access decode wrong");

  property p_rom_decode;
    @(posedge i_mclk) disable iff (!rst_n)
      i_req[0] && !o_rom_unmap_select && i_addr_prog >= `OMMD_CPU_ROM_BASE
      && i_addr_prog <= `OMMD_CPU_ROM_END
      |=> o_ack[0] && o_region[0] == REGION_ROM
      && o_waddr[0] == $past(i_addr_prog[`OMMD_ROM_WRD_HI:`OMMD_WRD_LO]);
  endproperty
  a_rom_decode: assert property (p_rom_decode) // R6 R11
    else $error("rom decode wrong");

  property p_mmr_flag;
    @(posedge i_mclk) disable iff (!rst_n)
      i_req[1] && i_addr_data < `OMMD_MMR_END
      |=> o_ack[1] && o_mmr[1] && o_region[1] == REGION_NONE;
  endproperty
  a_mmr_flag: assert property (p_mmr_flag) // R5
    else $error("register window not flagged");

  property p_dma_dual;
    @(posedge i_mclk) disable iff (!rst_n)
      i_req[2] && i_req[1:0] == 2'h0 && i_addr_dma >= `OMMD_DMA_DA_BASE + `OMMD_MMR_END
      && i_addr_dma <= `OMMD_DMA_DA_END
      |=> o_ack[2] && o_region[2] == REGION_DUAL
      && o_waddr[2] == {2'h0, $past(i_addr_dma[`OMMD_RAM_WRD_HI:`OMMD_WRD_LO])};
  endproperty
  a_dma_dual: assert property (p_dma_dual) // R4 R18
    else $error("dma dual-access decode wrong");

  property p_unmap_follow;
    @(posedge i_mclk) disable iff (!rst_n)
      i_unmap_wr |=> o_rom_unmap_select == $past(i_unmap_wdata);
  endproperty
  a_unmap_follow: assert property (p_unmap_follow) // R7
    else $error("rom unmap bit did not follow write");

endmodule : ommd_decoder
`default_nettype wire

// ---- core/ommd_unused.sv ----
// (no content)

// ---- tb/ommd_master_model.sv ----
// bus master model: four masters, each holding its request until acknowledged
`timescale 1ns/1ps
`default_nettype none
module ommd_master_model (
  input  wire logic             i_mclk,
  input  wire logic [3:0]       i_ack,
  input  wire logic [3:0]       i_cmd_valid,
  input  wire logic [3:0]       i_cmd_we,
  input  wire logic [3:0][31:0] i_cmd_addr,
  output var  logic [3:0]       o_req,
  output var  logic [3:0]       o_we,
  output var  logic [3:0][31:0] o_addr
);
  initial begin
    o_req  = 4'h0;
    o_we   = 4'h0;
    o_addr = '0;
  end

  // a stalled master keeps its request; an idle one scrambles its lines
  always @(negedge i_mclk) begin
    for (int m = 0; m < 4; m++) begin
      if (!o_req[m] || i_ack[m]) begin
        o_req[m]  <= i_cmd_valid[m];
        o_we[m]   <= i_cmd_valid[m] ? i_cmd_we[m] : ~o_we[m];
        o_addr[m] <= i_cmd_valid[m] ? i_cmd_addr[m] : ~o_addr[m];
      end
    end
  end
endmodule : ommd_master_model
`default_nettype wire

// ---- tb/tb.sv ----
// self-checking bench for the on-chip memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ommd_pkg::*;
  logic             i_mclk;
  logic             i_rst_n;
  logic             i_unmap_wr;
  logic             i_unmap_wdata;
  logic             i_soft_reset;
  logic             unmap_sel;
  logic             unmap_model;
  logic             booting;
  logic [3:0]       req, we, ack, mem_we, mmr, cmd_valid, cmd_we;
  logic [3:0][31:0] addr, cmd_addr;
  logic [3:0][3:0]  region;
  logic [3:0][4:0]  blk;
  logic [3:0][13:0] waddr;
  logic [31:0]      seed, r;
  int               errors, samples_checked;
  int               wait_cnt [4];

  initial begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  ommd_decoder #(.SA_BLOCKS(6'h20)) i_dut (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_req(req), .i_we(we),
    .i_addr_prog(addr[0]), .i_addr_data(addr[1]), .i_addr_dma(addr[2]),
    .i_addr_usb(addr[3]), .i_unmap_wr(i_unmap_wr), .i_unmap_wdata(i_unmap_wdata),
    .i_soft_reset(i_soft_reset), .o_ack(ack), .o_mem_we(mem_we), .o_mmr(mmr),
    .o_region(region), .o_blk(blk), .o_waddr(waddr), .o_rom_unmap_select(unmap_sel)
  );

  ommd_master_model i_masters (
    .i_mclk(i_mclk), .i_ack(ack), .i_cmd_valid(cmd_valid), .i_cmd_we(cmd_we),
    .i_cmd_addr(cmd_addr), .o_req(req), .o_we(we), .o_addr(addr)
  );

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] gen(input int m);
    logic [31:0] x;
    x = rnd();
    if (booting && &x[17:13]) x[13] = 1'b0;
    case (x[31:30])
      2'h0: gen = (m < 2) ? {16'h0, x[15:0]} : {16'h1, x[15:0]};
      2'h1: gen = ((m < 2) ? 32'h0001_0000 : 32'h0009_0000) + {14'h0, x[17:0]};
      2'h2: gen = {15'h7f, x[16:0]};
      default: gen = x;
    endcase
  endfunction : gen

  // expected {mmr, region, block, word} of one access
  function automatic logic [23:0] dec(input int m, input logic [31:0] a, input logic u);
    logic [3:0]  rg;
    logic [4:0]  b;
    logic [13:0] w;
    logic        k;
    logic [31:0] d;
    rg = 4'h1;
    b = 5'h0;
    w = {2'h0, a[12:1]};
    k = 1'b0;
    d = a - ((m < 2) ? 32'h0001_0000 : 32'h0009_0000);
    if (m < 2 && a < 32'h0000_00c0) k = 1'b1;
    else if (m == 2 && a >= 32'h0001_0000 && a < 32'h0001_00c0) k = 1'b1;
    else if ((m < 2 && a <= 32'h0000_ffff) || (m == 2 && a[31:16] == 16'h0001)) begin
      rg = 4'h2;
      b = {2'h0, a[15:13]};
    end else if (d < 32'h0004_0000) begin
      rg = 4'h4;
      b = d[17:13];
    end else if (m < 2 && a[31:17] == 15'h7f && !u) begin
      rg = 4'h8;
      b = {3'h0, a[16:15]};
      w = a[14:1];
    end
    return {k, rg, b, w};
  endfunction : dec

  always @(negedge i_mclk) begin : mon
    logic [23:0] e;
    int          n;
    if (i_rst_n) begin
      for (int m = 0; m < 4; m++) begin
        check("ack without request", ack[m] & ~req[m], 32'h0);
        if (ack[m] === 1'b1) begin
          e = dec(m, addr[m], unmap_model);
          check("region", region[m], e[22:19]);
          check("mmr", mmr[m], e[23]);
          check("mem_we", mem_we[m], we[m] && (m != 0) && (e[23] | e[20] | e[21]));
          if (e[22:19] != 4'h1) begin
            check("blk", blk[m], e[18:14]);
            check("waddr", waddr[m], e[13:0]);
            n = 0;
            for (int k = 0; k < 4; k++) begin
              if (ack[k] && region[k] === region[m] && blk[k] === blk[m]) n++;
            end
            check("block load", n <= (e[20] ? 2 : 1), 32'h1);
          end
          wait_cnt[m] = 0;
        end else if (req[m] === 1'b1) begin
          wait_cnt[m]++;
          if (wait_cnt[m] > 40) begin
            check("ack wait", wait_cnt[m], 32'h0);
            give_verdict();
          end
        end
      end
    end
  end

  task automatic hw_reset();
    @(negedge i_mclk);
    i_rst_n = 1'b0;
    unmap_model = 1'b0;
    repeat (16) @(negedge i_mclk);
    check("ack in reset", ack, 32'h0);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
  endtask : hw_reset

  task automatic soft_pulse(input logic exp);
    @(negedge i_mclk);
    i_soft_reset = 1'b1;
    @(negedge i_mclk);
    i_soft_reset = 1'b0;
    @(negedge i_mclk);
    check("unmap kept", unmap_sel, exp);
  endtask : soft_pulse

  task automatic set_unmap(input logic b);
    @(negedge i_mclk);
    i_unmap_wr = 1'b1;
    i_unmap_wdata = b;
    @(negedge i_mclk);
    i_unmap_wr = 1'b0;
    unmap_model = b;
    check("unmap bit", unmap_sel, b);
  endtask : set_unmap

  // one request per selected master, then acks expected nibble by nibble
  task automatic run(input logic [3:0] v, input logic [3:0] w, input logic [15:0] exp);
    @(posedge i_mclk);
    cmd_valid <= v;
    cmd_we <= w;
    @(posedge i_mclk);
    cmd_valid <= 4'h0;
    for (int i = 0; i < 4; i++) begin
      @(negedge i_mclk);
      check("ack", ack, exp[4*i +: 4]);
    end
  endtask : run

  initial begin
    i_rst_n = 1'b0;
    i_unmap_wr = 1'b0;
    i_unmap_wdata = 1'b0;
    i_soft_reset = 1'b0;
    cmd_valid = 4'h0;
    cmd_we = 4'h0;
    cmd_addr = '0;
    seed = 32'hc2f0;
    booting = 1'b1;
    errors = 0;
    samples_checked = 0;
    wait_cnt = '{default: 0};
    hw_reset();
    check("unmap after reset", unmap_sel, 32'h0);
    soft_pulse(1'b0);
    cmd_addr = {32'h0, 32'h0001_0100, 32'h0000_0102, 32'h0000_0100};
    run(4'h7, 4'h6, 16'h0043);
    cmd_addr = {32'h0009_0006, 32'h0009_0004, 32'h0001_0002, 32'h0001_0000};
    run(4'hf, 4'ha, 16'h8421);
    cmd_addr = {32'h0, 32'h00fe_0000, 32'h00fe_0002, 32'h00fe_0000};
    run(4'h7, 4'h0, 16'h0025);
    cmd_addr = {32'h0, 32'h0001_0200, 32'h0000_00be, 32'h0000_00c0};
    run(4'h7, 4'h6, 16'h0007);
    set_unmap(1'b1);
    soft_pulse(1'b1);
    cmd_addr = {32'h0, 32'h0, 32'h00fe_0002, 32'h00fe_0000};
    run(4'h3, 4'h2, 16'h0003);
    set_unmap(1'b0);
    set_unmap(1'b1);
    hw_reset();
    check("unmap after reset", unmap_sel, 32'h0);
    for (int c = 0; c < 3000; c++) begin
      @(negedge i_mclk);
      if (c == 1500) booting = 1'b0;
      r = rnd();
      cmd_valid <= r[3:0];
      cmd_we <= r[7:4];
      i_soft_reset <= &r[10:8];
      for (int m = 0; m < 4; m++) cmd_addr[m] <= gen(m);
    end
    cmd_valid <= 4'h0;
    for (int i = 0; i < 100 && req !== 4'h0; i++) @(negedge i_mclk);
    check("drain", req, 32'h0);
    cmd_addr = {32'h000c_fffe, 32'h0001_fffe, 32'h0000_fffe, 32'h0004_fffe};
    run(4'hf, 4'h6, 16'h0087);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
